// ### logic/hsq_pkg.sv
// package of constants for the homing sequencer
package hsq_pkg;

	// ==========================================
	// register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_METHOD  = 8'h04;
	localparam logic [7:0] REG_SPD_HI  = 8'h08;
	localparam logic [7:0] REG_SPD_LO  = 8'h0C;
	localparam logic [7:0] REG_HOFFS   = 8'h10;
	localparam logic [7:0] REG_CALC    = 8'h14;
	localparam logic [7:0] REG_STATUS  = 8'h18;
	localparam logic [7:0] REG_POSFB   = 8'h1C;
	localparam logic [7:0] REG_TIMEOUT = 8'h20;

	// ==========================================
	// field positions and reset values
	localparam int          CTRL_START_BIT   = 4;
	localparam int          STAT_REACHED_BIT = 10;
	localparam int          STAT_ATTAIN_BIT  = 12;
	localparam int          STAT_ERROR_BIT   = 13;
	localparam int          STAT_FOUND_BIT   = 15;
	localparam logic [7:0]  METHOD_RST       = 8'h01;
	localparam logic [31:0] SPEED_RST        = 32'h0000_0064;
	localparam logic [31:0] TIMEOUT_RST      = 32'h0000_0000;

	// ==========================================
	// input vector layout for the edge sampler
	localparam int IN_HOME = 0;
	localparam int IN_NLIM = 1;
	localparam int IN_PLIM = 2;
	localparam int IN_IDX  = 3;
	localparam int IN_W    = 4;

	// ==========================================
	// homing methods handled here
	localparam logic [7:0] M_NLIM  = 8'h01;
	localparam logic [7:0] M_PLIM  = 8'h02;
	localparam logic [7:0] M_H3    = 8'h03;
	localparam logic [7:0] M_H4    = 8'h04;
	localparam logic [7:0] M_H5    = 8'h05;
	localparam logic [7:0] M_H6    = 8'h06;
	localparam logic [7:0] M_H7    = 8'h07;
	localparam logic [7:0] M_H8    = 8'h08;
	localparam logic [7:0] M_H9    = 8'h09;

	// direction encoding on the motor port
	localparam logic DIR_POS = 1'b1;
	localparam logic DIR_NEG = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FAST,
		ST_SLOW,
		ST_SLOW2,
		ST_ZERO,
		ST_DONE
	} hsq_state_t;

endpackage

// ### logic/hsq_edge.sv
// edge sampler for switch and index inputs
`timescale 1ns/100ps
module hsq_edge
#(
	parameter int W = 4
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// raw levels
	input  wire logic [W-1:0] lvl,
	// edge strobes, one cycle each
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	// ==========================================
	// previous level
	logic [W-1:0] prev_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			prev_q <= '0;
		else
			prev_q <= lvl;
	end

	// edges against the held level; inputs are already synchronous
	assign rise = lvl & ~prev_q;
	assign fall = ~lvl & prev_q;

endmodule

// ### logic/hsq_homing_sequencer.sv
// homing sequencer with apb register access
`timescale 1ns/100ps
module hsq_homing_sequencer
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// switches and encoder
	input  wire logic        home_sw,
	input  wire logic        neg_lim,
	input  wire logic        pos_lim,
	input  wire logic        enc_index,
	input  wire logic [31:0] enc_pos,
	input  wire logic        pos_dev_err,
	// motor command
	output logic             mot_run,
	output logic             mot_dir,
	output logic      [31:0] mot_speed,
	output logic      [31:0] pos_fb
);

	// ==========================================
	// declarations
	logic [15:0]               ctrl_q;
	logic [7:0]                method_q;
	logic [31:0]               spd_hi_q;
	logic [31:0]               spd_lo_q;
	logic [31:0]               hoffs_q;
	logic                      calc_q;
	logic [31:0]               timeout_q;
	logic [31:0]               bias_q;
	logic [31:0]               pos_fb_q;
	logic [31:0]               tmo_cnt_q;
	logic                      run_prev_q;
	logic                      reached_q;
	logic                      attain_q;
	logic                      error_q;
	logic                      found_q;
	logic                      lim_hit_q;
	logic                      dir_q;
	logic                      fast_q;
	logic [31:0]               prdata_q;
	logic                      err_q;
	hsq_pkg::hsq_state_t       st_q;
	logic [hsq_pkg::IN_W-1:0]  lvl;
	logic [hsq_pkg::IN_W-1:0]  rise;
	logic [hsq_pkg::IN_W-1:0]  fall;
	logic                      wr;
	logic                      setup;
	logic                      go;
	logic                      start;
	logic                      stop;
	logic                      busy;
	logic                      tmo_hit;
	logic                      fault;
	logic                      home_r;
	logic                      home_f;
	logic                      zero_hit;
	logic [15:0]               status;

	// ==========================================
	// decode helpers
	function automatic logic known_reg(input logic [7:0] a);
		unique case (a)
			hsq_pkg::REG_CTRL, hsq_pkg::REG_METHOD, hsq_pkg::REG_SPD_HI,
			hsq_pkg::REG_SPD_LO, hsq_pkg::REG_HOFFS, hsq_pkg::REG_CALC,
			hsq_pkg::REG_STATUS, hsq_pkg::REG_POSFB,
			hsq_pkg::REG_TIMEOUT:
				known_reg = 1'b1;
			default:
				known_reg = 1'b0;
		endcase
	endfunction

	function automatic logic is_wr(input logic w, input logic [7:0] a,
		input logic [7:0] r);
		is_wr = w && (a == r);
	endfunction

	// ==========================================
	// input edges
	assign lvl[hsq_pkg::IN_HOME] = home_sw;
	assign lvl[hsq_pkg::IN_NLIM] = neg_lim;
	assign lvl[hsq_pkg::IN_PLIM] = pos_lim;
	assign lvl[hsq_pkg::IN_IDX]  = enc_index;

	hsq_edge #(
		.W (hsq_pkg::IN_W)
	) u_edge (
		.clk  (clk),
		.nrst (nrst),
		.lvl  (lvl),
		.rise (rise),
		.fall (fall)
	);

	assign home_r = rise[hsq_pkg::IN_HOME];
	assign home_f = fall[hsq_pkg::IN_HOME];

	// ==========================================
	// apb access, zero wait states
	assign setup   = psel && !penable;
	assign wr      = psel && penable && pwrite && known_reg(paddr);
	assign pready  = psel && penable;
	assign pslverr = psel && penable && err_q;
	assign prdata  = prdata_q;

	assign status = {(16'h0000 | ({15'h0000, found_q}
			<< hsq_pkg::STAT_FOUND_BIT)
		| ({15'h0000, error_q} << hsq_pkg::STAT_ERROR_BIT)
		| ({15'h0000, attain_q} << hsq_pkg::STAT_ATTAIN_BIT)
		| ({15'h0000, reached_q} << hsq_pkg::STAT_REACHED_BIT))};

	// read data is captured in setup so it leaves a flip-flop
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end
		else if (setup)
		begin
			err_q <= !known_reg(paddr);
			unique case (paddr)
				hsq_pkg::REG_CTRL:    prdata_q <= {16'h0000, ctrl_q};
				hsq_pkg::REG_METHOD:  prdata_q <= {24'h000000, method_q};
				hsq_pkg::REG_SPD_HI:  prdata_q <= spd_hi_q;
				hsq_pkg::REG_SPD_LO:  prdata_q <= spd_lo_q;
				hsq_pkg::REG_HOFFS:   prdata_q <= hoffs_q;
				hsq_pkg::REG_CALC:    prdata_q <= {31'h0, calc_q};
				hsq_pkg::REG_STATUS:  prdata_q <= {16'h0000, status};
				hsq_pkg::REG_POSFB:   prdata_q <= pos_fb_q;
				hsq_pkg::REG_TIMEOUT: prdata_q <= timeout_q;
				default:              prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================
	// configuration registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_q    <= 16'h0000;
			method_q  <= hsq_pkg::METHOD_RST;
			spd_hi_q  <= hsq_pkg::SPEED_RST;
			spd_lo_q  <= hsq_pkg::SPEED_RST;
			hoffs_q   <= 32'h0000_0000;
			calc_q    <= 1'b0;
			timeout_q <= hsq_pkg::TIMEOUT_RST;
		end
		else
		begin
			if (is_wr(wr, paddr, hsq_pkg::REG_CTRL))
				ctrl_q <= pwdata[15:0];
			if (is_wr(wr, paddr, hsq_pkg::REG_METHOD))
				method_q <= pwdata[7:0];
			if (is_wr(wr, paddr, hsq_pkg::REG_SPD_HI))
				spd_hi_q <= pwdata;
			if (is_wr(wr, paddr, hsq_pkg::REG_SPD_LO))
				spd_lo_q <= pwdata;
			if (is_wr(wr, paddr, hsq_pkg::REG_HOFFS))
				hoffs_q <= pwdata;
			if (is_wr(wr, paddr, hsq_pkg::REG_CALC))
				calc_q <= pwdata[0];
			if (is_wr(wr, paddr, hsq_pkg::REG_TIMEOUT))
				timeout_q <= pwdata;
		end
	end

	// ==========================================
	// start and end of homing from control bit four
	assign go    = ctrl_q[hsq_pkg::CTRL_START_BIT];
	assign start = go && !run_prev_q;
	assign stop  = !go;
	assign busy  = (st_q != hsq_pkg::ST_IDLE)
		&& (st_q != hsq_pkg::ST_DONE);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			run_prev_q <= 1'b0;
		else
			run_prev_q <= go;
	end

	// ==========================================
	// timeout and deviation supervision
	assign tmo_hit = (timeout_q != 32'h0000_0000)
		&& (tmo_cnt_q >= timeout_q);
	assign fault   = busy && (tmo_hit || pos_dev_err);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			tmo_cnt_q <= 32'h0000_0000;
		else if (start || !busy)
			tmo_cnt_q <= 32'h0000_0000;
		else if (!tmo_hit)
			tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
	end

	// ==========================================
	// sequencer
	assign zero_hit = (st_q == hsq_pkg::ST_ZERO)
		&& rise[hsq_pkg::IN_IDX];

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q      <= hsq_pkg::ST_IDLE;
			dir_q     <= hsq_pkg::DIR_POS;
			fast_q    <= 1'b0;
			lim_hit_q <= 1'b0;
		end
		else if (stop || fault)
			st_q <= hsq_pkg::ST_IDLE;
		else if (start)
		begin
			lim_hit_q <= 1'b0;
			// start case taken from the input levels right now
			unique case (method_q)
				hsq_pkg::M_NLIM:
				begin
					st_q <= hsq_pkg::ST_FAST;
					dir_q <= hsq_pkg::DIR_NEG;
					fast_q <= 1'b1;
				end
				hsq_pkg::M_PLIM:
				begin
					st_q <= hsq_pkg::ST_FAST;
					dir_q <= hsq_pkg::DIR_POS;
					fast_q <= 1'b1;
				end
				hsq_pkg::M_H3:
				begin
					st_q <= home_sw ? hsq_pkg::ST_SLOW : hsq_pkg::ST_FAST;
					dir_q <= home_sw ? hsq_pkg::DIR_NEG : hsq_pkg::DIR_POS;
					fast_q <= !home_sw;
				end
				hsq_pkg::M_H4:
				begin
					// direction for the low case is not given: slow forward
					st_q <= home_sw ? hsq_pkg::ST_FAST : hsq_pkg::ST_SLOW;
					dir_q <= home_sw ? hsq_pkg::DIR_NEG : hsq_pkg::DIR_POS;
					fast_q <= home_sw;
				end
				hsq_pkg::M_H5:
				begin
					st_q <= home_sw ? hsq_pkg::ST_SLOW : hsq_pkg::ST_FAST;
					dir_q <= home_sw ? hsq_pkg::DIR_POS : hsq_pkg::DIR_NEG;
					fast_q <= !home_sw;
				end
				hsq_pkg::M_H6:
				begin
					st_q <= home_sw ? hsq_pkg::ST_FAST : hsq_pkg::ST_SLOW;
					dir_q <= home_sw ? hsq_pkg::DIR_POS : hsq_pkg::DIR_NEG;
					fast_q <= home_sw;
				end
				hsq_pkg::M_H7, hsq_pkg::M_H8:
				begin
					st_q <= home_sw ? hsq_pkg::ST_SLOW2 : hsq_pkg::ST_FAST;
					dir_q <= home_sw ? hsq_pkg::DIR_NEG : hsq_pkg::DIR_POS;
					fast_q <= !home_sw;
				end
				hsq_pkg::M_H9:
				begin
					st_q <= hsq_pkg::ST_FAST;
					dir_q <= hsq_pkg::DIR_POS;
					fast_q <= 1'b1;
				end
				default:
					st_q <= hsq_pkg::ST_IDLE;
			endcase
		end
		else
		begin
			unique case (st_q)
				hsq_pkg::ST_FAST:
				begin
					if ((method_q == hsq_pkg::M_NLIM
						|| method_q == hsq_pkg::M_H5) && neg_lim)
					begin
						st_q <= hsq_pkg::ST_SLOW;
						dir_q <= hsq_pkg::DIR_POS;
						fast_q <= 1'b0;
					end
					else if (method_q == hsq_pkg::M_PLIM && pos_lim)
					begin
						st_q <= hsq_pkg::ST_SLOW;
						dir_q <= hsq_pkg::DIR_NEG;
						fast_q <= 1'b0;
					end
					else if (method_q >= hsq_pkg::M_H7 && !lim_hit_q
						&& pos_lim)
					begin
						lim_hit_q <= 1'b1;
						dir_q <= hsq_pkg::DIR_NEG;
					end
					else if (home_r && (method_q == hsq_pkg::M_H3))
					begin
						st_q <= hsq_pkg::ST_ZERO;
						dir_q <= hsq_pkg::DIR_NEG;
						fast_q <= 1'b0;
					end
					else if (home_f && (method_q == hsq_pkg::M_H4
						|| method_q == hsq_pkg::M_H6))
					begin
						st_q <= hsq_pkg::ST_ZERO;
						dir_q <= ~dir_q;
						fast_q <= 1'b0;
					end
					else if (home_r && method_q == hsq_pkg::M_H7)
					begin
						st_q <= lim_hit_q ? hsq_pkg::ST_ZERO
							: hsq_pkg::ST_SLOW2;
						dir_q <= hsq_pkg::DIR_NEG;
						fast_q <= 1'b0;
					end
					else if (home_r && method_q == hsq_pkg::M_H8)
					begin
						st_q <= lim_hit_q ? hsq_pkg::ST_ZERO
							: hsq_pkg::ST_SLOW2;
						dir_q <= hsq_pkg::DIR_NEG;
						fast_q <= 1'b0;
					end
					else if (home_r && method_q == hsq_pkg::M_H9)
					begin
						st_q <= hsq_pkg::ST_SLOW2;
						dir_q <= hsq_pkg::DIR_POS;
						fast_q <= 1'b0;
					end
				end
				hsq_pkg::ST_SLOW:
				begin
					// slow leg ends on the edge that arms the index
					if ((method_q == hsq_pkg::M_NLIM && fall[hsq_pkg::IN_NLIM])
						|| (method_q == hsq_pkg::M_PLIM
						&& fall[hsq_pkg::IN_PLIM])
						|| (method_q == hsq_pkg::M_H5 && !lim_hit_q
						&& fall[hsq_pkg::IN_NLIM] && !home_sw)
						|| ((method_q == hsq_pkg::M_H3
						|| method_q == hsq_pkg::M_H5) && home_f)
						|| ((method_q == hsq_pkg::M_H4
						|| method_q == hsq_pkg::M_H6) && home_r))
						st_q <= hsq_pkg::ST_ZERO;
				end
				hsq_pkg::ST_SLOW2:
				begin
					if (home_f)
					begin
						st_q <= hsq_pkg::ST_ZERO;
						if (method_q == hsq_pkg::M_H8)
							dir_q <= hsq_pkg::DIR_POS;
						else if (method_q == hsq_pkg::M_H9)
							dir_q <= hsq_pkg::DIR_NEG;
					end
				end
				hsq_pkg::ST_ZERO:
				begin
					if (zero_hit)
						st_q <= hsq_pkg::ST_DONE;
				end
				default:
				begin
				end
			endcase
		end
	end

	// ==========================================
	// motor command, stopped outside the search legs
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mot_run   <= 1'b0;
			mot_dir   <= hsq_pkg::DIR_POS;
			mot_speed <= 32'h0000_0000;
		end
		else
		begin
			mot_run   <= busy && !zero_hit && !stop && !fault;
			mot_dir   <= dir_q;
			// speed drops with run so an abort never leaves a command
			mot_speed <= (busy && !zero_hit && !stop && !fault)
				? (fast_q ? spd_hi_q : spd_lo_q) : 32'h0000_0000;
		end
	end

	// ==========================================
	// status flags; a set in the start cycle still wins
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reached_q <= 1'b0;
			attain_q  <= 1'b0;
			error_q   <= 1'b0;
			found_q   <= 1'b0;
		end
		else
		begin
			if (zero_hit && !stop && !fault)
			begin
				reached_q <= 1'b1;
				attain_q  <= 1'b1;
			end
			else if (start)
			begin
				reached_q <= 1'b0;
				attain_q  <= 1'b0;
			end
			if (fault)
				error_q <= 1'b1;
			else if (start)
				error_q <= 1'b0;
			if (busy && (home_r || home_f))
				found_q <= 1'b1;
			else if (start)
				found_q <= 1'b0;
		end
	end

	// ==========================================
	// position feedback rebased at the zero point
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			bias_q <= 32'h0000_0000;
		else if (zero_hit && !stop && !fault)
		begin
			if (calc_q)
				bias_q <= bias_q + hoffs_q;
			else
				bias_q <= hoffs_q - enc_pos;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pos_fb_q <= 32'h0000_0000;
		else
			pos_fb_q <= enc_pos + bias_q;
	end

	assign pos_fb = pos_fb_q;

endmodule

// ### dv/hsq_checker_sva.sv
// assertion checker for the homing sequencer ports
`timescale 1ns/100ps
module hsq_checker
(
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// switches and motor
	input wire logic        neg_lim,
	input wire logic        pos_lim,
	input wire logic        pos_dev_err,
	input wire logic        mot_run,
	input wire logic        mot_dir,
	input wire logic [31:0] mot_speed
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic acc;
	assign acc = psel && penable;
	// ========
	// bus
	ready_high_a:
	assert property (acc |-> pready)
		else $error("pready low in access phase");
	unmapped_err_a:
	assert property (acc && paddr > 8'h20 |-> pslverr)
		else $error("unmapped access without error");
	mapped_ok_a:
	assert property (acc && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped access");
	// ========
	// motion
	abort_stop_a:
	assert property (acc && pwrite && paddr == hsq_pkg::REG_CTRL
		&& !pwdata[hsq_pkg::CTRL_START_BIT] |-> ##[1:4] !mot_run)
		else $error("motor still running after abort");
	fault_stop_a:
	assert property (mot_run && pos_dev_err |-> ##[1:4] !mot_run)
		else $error("motor still running after deviation");
	neg_turn_a:
	assert property (mot_run && mot_dir == hsq_pkg::DIR_NEG && $rose(neg_lim)
		|-> ##[1:4] mot_dir == hsq_pkg::DIR_POS)
		else $error("no turn at negative limit");
	pos_turn_a:
	assert property (mot_run && mot_dir == hsq_pkg::DIR_POS && $rose(pos_lim)
		|-> ##[1:4] mot_dir == hsq_pkg::DIR_NEG)
		else $error("no turn at positive limit");
	stop_speed_a:
	assert property (!mot_run |-> mot_speed == 32'h0)
		else $error("speed while stopped");
	run_speed_a:
	assert property ($rose(mot_run) |-> mot_speed != 32'h0)
		else $error("running with zero speed");
	cover property ($fell(mot_run));
	cover property ($rose(pslverr));
	cover property ($rose(pos_lim) && mot_run);
endmodule

bind hsq_homing_sequencer hsq_checker hsq_checker_inst (.clk, .nrst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .neg_lim,
	.pos_lim, .pos_dev_err, .mot_run, .mot_dir, .mot_speed);

// ### dv/hsq_motor_model.sv
// behavioural motor, encoder and switch model
`timescale 1ns/100ps
module hsq_motor_model
#(
	parameter int HOME_LO = 165,
	parameter int HOME_HI = 204,
	parameter int POS_END = 320
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// position preset from the bench
	input  wire logic        load,
	input  wire logic [31:0] load_pos,
	// motor command
	input  wire logic        mot_run,
	input  wire logic        mot_dir,
	// encoder and switches
	output logic      [31:0] enc_pos,
	output logic             home_sw,
	output logic             neg_lim,
	output logic             pos_lim,
	output logic             enc_index
);
	// ========
	// one step per 8 cycles so a stop lands before the next step
	logic [2:0] tick_q;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			enc_pos <= 32'h0;
			tick_q  <= 3'h0;
		end
		else if (load)
		begin
			enc_pos <= load_pos;
			tick_q  <= 3'h0;
		end
		else if (mot_run)
		begin
			tick_q <= tick_q + 3'h1;
			if (tick_q == 3'h7)
				enc_pos <= (mot_dir == hsq_pkg::DIR_POS) ? enc_pos + 32'h1
					: enc_pos - 32'h1;
		end
		else
			tick_q <= 3'h0;
	end
	// ========
	// switches; index every 16 counts, off the home cam edges
	assign home_sw   = $signed(enc_pos) >= HOME_LO && $signed(enc_pos) <= HOME_HI;
	assign neg_lim   = $signed(enc_pos) <= 0;
	assign pos_lim   = $signed(enc_pos) >= POS_END;
	assign enc_index = enc_pos[3:0] == 4'h0;
endmodule

// ### dv/hsq_homing_sequencer_tb_top.sv
// testbench top for the homing sequencer
`timescale 1ns/100ps
module hsq_homing_sequencer_tb_top;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, er;
	logic        home_sw, neg_lim, pos_lim, enc_index, pos_dev_err;
	logic        mot_run, mot_dir, load, calc;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, enc_pos, mot_speed, pos_fb;
	logic [31:0] load_pos, bias, rd;
	int          error_cnt, checked, cyc;
	localparam logic [31:0] OFFS = 32'h0000_1234;

	hsq_homing_sequencer hsq_homing_sequencer_inst (.clk, .nrst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.home_sw, .neg_lim, .pos_lim, .enc_index, .enc_pos, .pos_dev_err,
		.mot_run, .mot_dir, .mot_speed, .pos_fb);
	hsq_motor_model hsq_motor_model_inst (.clk, .nrst, .load, .load_pos,
		.mot_run, .mot_dir, .enc_pos, .home_sw, .neg_lim, .pos_lim,
		.enc_index);

	always #2 clk = ~clk;
	// ========
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	// ========
	// shared tasks
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
			error_cnt++;
	endtask
	task automatic wait_run(input logic v, input int lim);
		int n;
		n = 0;
		while (mot_run !== v && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		cmp({31'h0, mot_run}, {31'h0, v});
	endtask
	task automatic prep(input logic [7:0] m, input int st);
		apb(1'b1, hsq_pkg::REG_CTRL, 32'h0);
		load <= 1'b1;
		load_pos <= 32'(st);
		@(posedge clk);
		load <= 1'b0;
		apb(1'b1, hsq_pkg::REG_METHOD, {24'h0, m});
		apb(1'b1, hsq_pkg::REG_CTRL, 32'h0000_0010);
	endtask
	task automatic home_case(input logic [7:0] m, input int st, input int ex);
		prep(m, st);
		wait_run(1'b1, 10);
		wait_run(1'b0, 5000);
		repeat (4) @(posedge clk);
		bias = calc ? bias + OFFS : OFFS - 32'(ex);
		cmp(enc_pos, 32'(ex));
		cmp(pos_fb, 32'(ex) + bias);
		apb(1'b0, hsq_pkg::REG_STATUS, 32'h0);
		cmp(rd & 32'h0000_3400, 32'h0000_1400);
	endtask
	// ========
	// scenarios
	task automatic t_regs();
		apb(1'b0, hsq_pkg::REG_METHOD, 32'h0);
		cmp(rd, {24'h0, hsq_pkg::METHOD_RST});
		apb(1'b0, hsq_pkg::REG_SPD_HI, 32'h0);
		cmp(rd, hsq_pkg::SPEED_RST);
		apb(1'b0, hsq_pkg::REG_SPD_LO, 32'h0);
		cmp(rd, hsq_pkg::SPEED_RST);
		apb(1'b0, hsq_pkg::REG_STATUS, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		cmp({31'h0, er}, 32'h1);
		apb(1'b1, hsq_pkg::REG_HOFFS, OFFS);
		apb(1'b0, hsq_pkg::REG_HOFFS, 32'h0);
		cmp(rd, OFFS);
		apb(1'b1, hsq_pkg::REG_SPD_HI, 32'h0000_00C8);
		apb(1'b0, hsq_pkg::REG_SPD_HI, 32'h0);
		cmp(rd, 32'h0000_00C8);
		$display("registers done");
	endtask
	task automatic t_limit();
		home_case(hsq_pkg::M_NLIM, 100, 16);
		home_case(hsq_pkg::M_PLIM, 250, 304);
		home_case(hsq_pkg::M_H5, 100, 16);
		$display("limit methods done");
	endtask
	task automatic t_home();
		home_case(hsq_pkg::M_H3, 100, 160);
		home_case(hsq_pkg::M_H3, 180, 160);
		home_case(hsq_pkg::M_H4, 100, 176);
		home_case(hsq_pkg::M_H4, 180, 176);
		home_case(hsq_pkg::M_H5, 180, 208);
		home_case(hsq_pkg::M_H6, 250, 192);
		home_case(hsq_pkg::M_H6, 180, 192);
		$display("home methods done");
	endtask
	task automatic t_fwd();
		home_case(hsq_pkg::M_H7, 100, 160);
		home_case(hsq_pkg::M_H7, 250, 192);
		home_case(hsq_pkg::M_H7, 180, 160);
		home_case(hsq_pkg::M_H8, 100, 176);
		home_case(hsq_pkg::M_H8, 250, 192);
		home_case(hsq_pkg::M_H8, 180, 176);
		home_case(hsq_pkg::M_H9, 100, 192);
		home_case(hsq_pkg::M_H9, 250, 192);
		$display("forward methods done");
	endtask
	task automatic t_rel();
		calc = 1'b1;
		apb(1'b1, hsq_pkg::REG_CALC, 32'h1);
		home_case(hsq_pkg::M_NLIM, 100, 16);
		calc = 1'b0;
		apb(1'b1, hsq_pkg::REG_CALC, 32'h0);
		$display("relative done");
	endtask
	task automatic t_abort();
		prep(hsq_pkg::M_PLIM, 250);
		wait_run(1'b1, 10);
		cmp(mot_speed, 32'h0000_00C8);
		cmp({31'h0, mot_dir}, {31'h0, hsq_pkg::DIR_POS});
		repeat (20) @(posedge clk);
		apb(1'b1, hsq_pkg::REG_CTRL, 32'h0);
		wait_run(1'b0, 6);
		apb(1'b0, hsq_pkg::REG_STATUS, 32'h0);
		cmp(rd & 32'h0000_3400, 32'h0);
		prep(hsq_pkg::M_H6, 250);
		wait_run(1'b1, 10);
		cmp(mot_speed, hsq_pkg::SPEED_RST);
		cmp({31'h0, mot_dir}, {31'h0, hsq_pkg::DIR_NEG});
		prep(8'h0A, 100);
		repeat (10) @(posedge clk);
		cmp({31'h0, mot_run}, 32'h0);
		$display("abort done");
	endtask
	task automatic t_faults();
		apb(1'b1, hsq_pkg::REG_TIMEOUT, 32'h0000_0032);
		prep(hsq_pkg::M_NLIM, 100);
		wait_run(1'b1, 10);
		wait_run(1'b0, 200);
		apb(1'b0, hsq_pkg::REG_STATUS, 32'h0);
		cmp(rd & 32'h0000_3000, 32'h0000_2000);
		apb(1'b1, hsq_pkg::REG_TIMEOUT, 32'h0);
		prep(hsq_pkg::M_NLIM, 100);
		wait_run(1'b1, 10);
		repeat (20) @(posedge clk);
		pos_dev_err <= 1'b1;
		@(posedge clk);
		pos_dev_err <= 1'b0;
		wait_run(1'b0, 6);
		apb(1'b0, hsq_pkg::REG_STATUS, 32'h0);
		cmp(rd & 32'h0000_3000, 32'h0000_2000);
		$display("faults done");
	endtask
	// ========
	// main sequence
	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pos_dev_err = 1'b0;
		load = 1'b0;
		load_pos = 32'h0;
		calc = 1'b0;
		bias = 32'h0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_limit();
		t_home();
		t_fwd();
		t_rel();
		t_abort();
		t_faults();
		finish_test();
	end
endmodule
